//--- verilog/phase_accumulator_oscillator.v
// phase accumulator oscillator with AXI4-Lite register access
// assumes source clocks are pins sampled on aclk; source must run below aclk/2
// Function
// RULE1 - 20-bit accumulator readable and writable as low, high, upper bytes
// RULE2 - each source rising edge: accumulator becomes accumulator plus buffered step
// RULE3 - carry out of the addition is the raw overflow pulse
// RULE4 - 20-bit step held in low, high, upper read/write byte registers
// RULE5 - software writes upper and high step bytes before the low byte
// RULE6 - enabled: low byte write loads buffer on second source rising edge
// RULE7 - disabled: any step write copies step into buffer at once
// RULE8 - adder uses hidden double-buffered step, invisible to software
// RULE9 - fixed duty mode toggles output on each overflow
// RULE10 - control bit 0 set selects pulse mode, clear selects fixed duty
// RULE11 - pulse mode: output active from edge after overflow for selected width
// RULE12 - width field gives two to the code source periods, 1 to 128
// RULE13 - width field ignored in fixed duty mode
// RULE14 - software keeps pulse width below the overflow period
// RULE15 - output inverted last when polarity bit 4 is set
// RULE16 - polarity change with interrupts enabled flags the resulting transition
// RULE17 - clock field picks oscillator, fast oscillator, logic cells one to four
// RULE18 - overflow sets flag; request needs module, flag, peripheral, global enables
// RULE19 - software clears the flag; hardware never clears it
// RULE20 - any reset clears every register to zero
// RULE21 - control bit 5 reads output, bit 7 enables the module
// RULE22 - runs in sleep; fast oscillator kept on when enabled and selected
// RULE23 - software does not write accumulator bytes while running
// RULE24 - accumulator wraps modulo two to the twentieth
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "nco_regs.vh"

module phase_accumulator_oscillator (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire osc_clock,
	input wire internal_fast_osc,
	input wire logic_cell_one_output,
	input wire logic_cell_two_output,
	input wire logic_cell_three_output,
	input wire logic_cell_four_output,
	output reg nco_out,
	output reg irq_request,
	output reg fast_osc_keep_on
);

// ************************************************
// registers
// ************************************************
reg module_on_q;
reg output_invert_q;
reg pulse_mode_select_q;
reg [2:0] pulse_width_sel_q;
reg [2:0] clock_source_sel_q;
reg [19:0] accum_q;
reg [19:0] step_q;
reg [19:0] step_buf_q;
reg overflow_flag_q;
reg overflow_irq_enable_q;
reg peripheral_irq_enable_q;
reg global_irq_enable_q;
reg [1:0] load_pend_q;
reg core_out_q;
reg [7:0] width_cnt_q;
reg out_final_q;
reg [5:0] src_meta_q;
reg [5:0] src_sync_q;
reg src_prev_q;
reg aw_held_q;
reg w_held_q;
reg [7:0] aw_addr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_upper_ok_q;

// ************************************************
// source clock selection and edge detect
// ************************************************
reg src_sel;
always @*
begin
	// RULE17 clock source mux
	if (clock_source_sel_q == 3'h0)
		src_sel = src_sync_q[0];
	else if (clock_source_sel_q == 3'h1)
		src_sel = src_sync_q[1];
	else if (clock_source_sel_q == 3'h2)
		src_sel = src_sync_q[2];
	else if (clock_source_sel_q == 3'h3)
		src_sel = src_sync_q[3];
	else if (clock_source_sel_q == 3'h4)
		src_sel = src_sync_q[4];
	else if (clock_source_sel_q == 3'h5)
		src_sel = src_sync_q[5];
	else
		src_sel = 1'b0;
end

wire src_rise = src_sel & ~src_prev_q & module_on_q;
// RULE2 adder with buffered step
wire [20:0] sum = {1'b0, accum_q} + {1'b0, step_buf_q};
// RULE3 carry is the raw overflow
wire carry = src_rise & sum[20];
wire [7:0] width_len = 8'h01 << pulse_width_sel_q;

// ************************************************
// bus write decode
// ************************************************
wire do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
// a write above the 256-byte window must not alias onto the map
wire wr_lane = wstrb_q[0] & aw_upper_ok_q;
wire [7:0] wbyte = wdata_q[7:0];
wire wr_ctrl = do_write & wr_lane & (aw_addr_q == `OFS_CONTROL);
wire wr_clk = do_write & wr_lane & (aw_addr_q == `OFS_CLOCK);
wire wr_accl = do_write & wr_lane & (aw_addr_q == `OFS_ACC_LOW);
wire wr_acch = do_write & wr_lane & (aw_addr_q == `OFS_ACC_HIGH);
wire wr_accu = do_write & wr_lane & (aw_addr_q == `OFS_ACC_UPPER);
wire wr_incl = do_write & wr_lane & (aw_addr_q == `OFS_STEP_LOW);
wire wr_inch = do_write & wr_lane & (aw_addr_q == `OFS_STEP_HIGH);
wire wr_incu = do_write & wr_lane & (aw_addr_q == `OFS_STEP_UPPER);
wire wr_irq = do_write & wr_lane & (aw_addr_q == `OFS_IRQ);
wire map_ok = (aw_addr_q[7:2] <= 6'h08) & (aw_addr_q[1:0] == 2'h0);
wire [19:0] step_new = {wr_incu ? wbyte[3:0] : step_q[19:16],
	wr_inch ? wbyte : step_q[15:8], wr_incl ? wbyte : step_q[7:0]};
wire out_next_pre = pulse_mode_select_q ? (width_cnt_q != 8'h00) : core_out_q;
wire inv_next = wr_ctrl ? wbyte[`BIT_OUTPUT_INVERT] : output_invert_q;

// ************************************************
// synchronisers and core
// ************************************************
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		src_meta_q <= 6'h00;
		src_sync_q <= 6'h00;
		src_prev_q <= 1'b0;
	end
	else
	begin
		src_meta_q <= {logic_cell_four_output, logic_cell_three_output, logic_cell_two_output,
			logic_cell_one_output, internal_fast_osc, osc_clock};
		src_sync_q <= src_meta_q;
		src_prev_q <= src_sel;
	end
end

always @(posedge aclk)
begin
	// RULE20 reset clears all
	if (!aresetn)
	begin
		module_on_q <= 1'b0;
		output_invert_q <= 1'b0;
		pulse_mode_select_q <= 1'b0;
		pulse_width_sel_q <= 3'h0;
		clock_source_sel_q <= 3'h0;
		accum_q <= `RESET_ZERO_20;
		step_q <= `RESET_ZERO_20;
		step_buf_q <= `RESET_ZERO_20;
		overflow_flag_q <= 1'b0;
		overflow_irq_enable_q <= 1'b0;
		peripheral_irq_enable_q <= 1'b0;
		global_irq_enable_q <= 1'b0;
		load_pend_q <= 2'h0;
		core_out_q <= 1'b0;
		width_cnt_q <= 8'h00;
		out_final_q <= 1'b0;
		nco_out <= 1'b0;
		irq_request <= 1'b0;
		fast_osc_keep_on <= 1'b0;
	end
	else
	begin
		if (wr_ctrl)
		begin
			// RULE21 enable bit
			module_on_q <= wbyte[`BIT_MODULE_ON];
			// RULE15 polarity bit
			output_invert_q <= wbyte[`BIT_OUTPUT_INVERT];
			// RULE10 mode select
			pulse_mode_select_q <= wbyte[`BIT_PULSE_MODE];
		end
		if (wr_clk)
		begin
			pulse_width_sel_q <= wbyte[7:5];
			clock_source_sel_q <= wbyte[2:0];
		end
		// RULE4 step byte registers
		step_q <= step_new;
		// RULE1 accumulator byte writes
		// RULE23 accumulator writes meant only when stopped
		if (wr_accl | wr_acch | wr_accu)
			accum_q <= {wr_accu ? wbyte[3:0] : accum_q[19:16],
				wr_acch ? wbyte : accum_q[15:8], wr_accl ? wbyte : accum_q[7:0]};
		else if (src_rise)
			// RULE24 wrap keeps low 20 bits
			accum_q <= sum[19:0];
		// RULE8 hidden double buffer
		if (!module_on_q)
		begin
			// RULE7 immediate load when stopped
			if (wr_incl | wr_inch | wr_incu)
				step_buf_q <= step_new;
			load_pend_q <= 2'h0;
		end
		else
		begin
			// RULE6 load on second source edge
			// RULE5 low byte write commits the step
			if (wr_incl)
				load_pend_q <= 2'h2;
			else if (src_rise && load_pend_q != 2'h0)
			begin
				load_pend_q <= load_pend_q - 2'h1;
				if (load_pend_q == 2'h1)
					step_buf_q <= step_q;
			end
		end
		if (carry)
			// RULE9 toggle on overflow
			core_out_q <= ~core_out_q;
		// RULE11 pulse starts on edge after overflow
		// RULE12 width is two to the code
		// RULE13 counter only used in pulse mode
		// RULE14 over-long widths simply restart
		if (carry)
			width_cnt_q <= width_len;
		else if (src_rise && width_cnt_q != 8'h00)
			width_cnt_q <= width_cnt_q - 8'h01;
		out_final_q <= out_next_pre ^ output_invert_q;
		nco_out <= out_next_pre ^ output_invert_q;
		// RULE19 only software clears
		if (wr_irq)
		begin
			overflow_irq_enable_q <= wbyte[`BIT_FLAG_EN];
			peripheral_irq_enable_q <= wbyte[`BIT_PERIPH_EN];
			global_irq_enable_q <= wbyte[`BIT_GLOBAL_EN];
		end
		// RULE18 overflow sets flag, set beats clear
		// RULE16 polarity flip flags the transition
		if (carry | (inv_next != output_invert_q && overflow_irq_enable_q))
			overflow_flag_q <= 1'b1;
		else if (wr_irq)
			overflow_flag_q <= wbyte[`BIT_FLAG];
		irq_request <= overflow_flag_q & module_on_q & overflow_irq_enable_q &
			peripheral_irq_enable_q & global_irq_enable_q;
		// RULE22 keep fast oscillator on
		fast_osc_keep_on <= module_on_q & (clock_source_sel_q == `SRC_FAST_OSC);
	end
end

// ************************************************
// axi4-lite slave
// ************************************************
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_held_q <= 1'b0;
		w_held_q <= 1'b0;
		aw_addr_q <= 8'h00;
		wdata_q <= 32'h00000000;
		wstrb_q <= 4'h0;
		aw_upper_ok_q <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end
	else
	begin
		s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
		s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
		if (s_axi_awvalid & s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr[7:0];
			aw_upper_ok_q <= (s_axi_awaddr[31:8] == 24'h000000);
		end
		if (s_axi_wvalid & s_axi_wready)
		begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= map_ok && aw_upper_ok_q ? `RESP_OKAY : `RESP_SLVERR;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
		end
		else if (s_axi_bvalid & s_axi_bready)
			s_axi_bvalid <= 1'b0;
		s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
		if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			if (s_axi_araddr[31:8] != 24'h000000)
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_SLVERR;
			end
			else if (s_axi_araddr[7:0] == `OFS_CONTROL)
				s_axi_rdata <= {24'h000000, module_on_q, 1'b0, out_final_q, output_invert_q, 3'h0,
					pulse_mode_select_q};
			else if (s_axi_araddr[7:0] == `OFS_CLOCK)
				s_axi_rdata <= {24'h000000, pulse_width_sel_q, 2'h0, clock_source_sel_q};
			else if (s_axi_araddr[7:0] == `OFS_ACC_LOW)
				s_axi_rdata <= {24'h000000, accum_q[7:0]};
			else if (s_axi_araddr[7:0] == `OFS_ACC_HIGH)
				s_axi_rdata <= {24'h000000, accum_q[15:8]};
			else if (s_axi_araddr[7:0] == `OFS_ACC_UPPER)
				s_axi_rdata <= {28'h0000000, accum_q[19:16]};
			else if (s_axi_araddr[7:0] == `OFS_STEP_LOW)
				s_axi_rdata <= {24'h000000, step_q[7:0]};
			else if (s_axi_araddr[7:0] == `OFS_STEP_HIGH)
				s_axi_rdata <= {24'h000000, step_q[15:8]};
			else if (s_axi_araddr[7:0] == `OFS_STEP_UPPER)
				s_axi_rdata <= {28'h0000000, step_q[19:16]};
			else if (s_axi_araddr[7:0] == `OFS_IRQ)
				s_axi_rdata <= {28'h0000000, global_irq_enable_q, peripheral_irq_enable_q,
					overflow_irq_enable_q, overflow_flag_q};
			else
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_SLVERR;
			end
		end
		else if (s_axi_rvalid & s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

endmodule // phase_accumulator_oscillator

//--- pkg/nco_regs.vh
// register map, field positions and reset values of the phase accumulator oscillator
// assumes a 32-bit AXI4-Lite slave, one byte register per aligned word
`ifndef NCO_REGS_VH
`define NCO_REGS_VH
`define OFS_CONTROL 8'h00
`define OFS_CLOCK 8'h04
`define OFS_ACC_LOW 8'h08
`define OFS_ACC_HIGH 8'h0C
`define OFS_ACC_UPPER 8'h10
`define OFS_STEP_LOW 8'h14
`define OFS_STEP_HIGH 8'h18
`define OFS_STEP_UPPER 8'h1C
`define OFS_IRQ 8'h20
`define BIT_MODULE_ON 7
`define BIT_OUTPUT_STATE 5
`define BIT_OUTPUT_INVERT 4
`define BIT_PULSE_MODE 0
`define BIT_FLAG 0
`define BIT_FLAG_EN 1
`define BIT_PERIPH_EN 2
`define BIT_GLOBAL_EN 3
`define ACC_WIDTH 20
`define RESET_ZERO_20 20'h00000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SRC_FAST_OSC 3'h1
`endif

//--- tb/phase_accumulator_oscillator_asserts.sv
// port checker for the phase accumulator oscillator
// assumes binding into phase_accumulator_oscillator, one aclk domain
`timescale 1ns/10ps
`include "nco_regs.vh"
module nco_port_checker (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire nco_out,
	input wire irq_request,
	input wire fast_osc_keep_on
);
	// ****************
	// checks
	// ****************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_RESET_CLEAR: assert property ($rose(aresetn) |-> !nco_out && !irq_request && !fast_osc_keep_on)
		else $error("outputs not clear after reset");
	AST_WRITE_ANSWER: assert property (s_wr |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	AST_READ_ANSWER: assert property (s_rd |-> ##[1:2] s_axi_rvalid)
		else $error("read not answered");
	AST_READ_REFUSED: assert property (s_rd ##0 (s_axi_araddr > 32'h20 || s_axi_araddr[1:0] != 2'h0)
		|-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR))
		else $error("unmapped read not refused");
	AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("unused read bits set");
	AST_ARREADY_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than a cycle");
	AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than a cycle");
	AST_KEEP_ON_CAUSE: assert property ($changed(fast_osc_keep_on)
		|-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("oscillator hold changed without a write");
endmodule // nco_port_checker
bind phase_accumulator_oscillator nco_port_checker i_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nco_out, .irq_request, .fast_osc_keep_on);

//--- tb/tb_phase_accumulator_oscillator.sv
// self-checking bench for the phase accumulator oscillator
// assumes the register map and bus timing of the design's hand-over
`timescale 1ns/10ps
`include "nco_regs.vh"
module tb_phase_accumulator_oscillator;
	// ****************
	// stimulus and tasks
	// ****************
	reg aclk = 1'h0, aresetn = 1'h0;
	reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
	reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	reg [5:0] src = 6'h00;
	reg [1:0] rr;
	wire awready, wready, bvalid, arready, rvalid, nco_out, irq_request, fast_osc_keep_on;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer n_fail = 0, check_count = 0, cycles = 0, i, w;
	phase_accumulator_oscillator i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.osc_clock(src[0]), .internal_fast_osc(src[1]), .logic_cell_one_output(src[2]),
		.logic_cell_two_output(src[3]), .logic_cell_three_output(src[4]), .logic_cell_four_output(src[5]),
		.nco_out(nco_out), .irq_request(irq_request), .fast_osc_keep_on(fast_osc_keep_on));
	always #5 aclk = ~aclk;
	// hang guard, well above the few thousand cycles needed
	always @(posedge aclk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			n_fail = n_fail + 1;
			final_report;
		end
	end
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge aclk);
			awaddr <= {24'h0, a};
			wdata <= {24'h0, d};
			awvalid <= 1'h1;
			wvalid <= 1'h1;
			bready <= 1'h1;
			do
			begin
				@(posedge aclk);
				if (awready === 1'h1) awvalid <= 1'h0;
				if (wready === 1'h1) wvalid <= 1'h0;
			end while (bvalid !== 1'h1);
			bready <= 1'h0;
		end
	endtask
	// rready offered with the address and held until rvalid is seen
	task rd_reg(input [7:0] a);
		begin
			@(posedge aclk);
			araddr <= {24'h0, a};
			arvalid <= 1'h1;
			rready <= 1'h1;
			do
			begin
				@(posedge aclk);
				if (arready === 1'h1) arvalid <= 1'h0;
			end while (rvalid !== 1'h1);
			rd = rdata;
			rr = rresp;
			rready <= 1'h0;
		end
	endtask
	// each pulse is 4 cycles high, well inside the sync limit
	task pulse(input [2:0] s, input integer n);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1)
			begin
				repeat (4) @(posedge aclk);
				src <= (s > 3'h5) ? 6'h3F : 6'h01 << s;
				repeat (4) @(posedge aclk);
				src <= 6'h00;
			end
			repeat (8) @(posedge aclk);
		end
	endtask
	task chk_reg(input [31:0] e);
		begin
			check_count = check_count + 1;
			if (rd !== e)
			begin
				n_fail = n_fail + 1;
				$display("unexpected register at %0t: got %h exp %h", $time, rd, e);
			end
		end
	endtask
	task chk_sig(input [1:0] g, input [1:0] e);
		begin
			check_count = check_count + 1;
			if (g !== e)
			begin
				n_fail = n_fail + 1;
				$display("unexpected signal at %0t: got %h exp %h", $time, g, e);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	// ****************
	// tests
	// ****************
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i <= 32; i = i + 4)
		begin
			rd_reg(i[7:0]);
			chk_reg(32'h0);
		end
		rd_reg(8'h24);
		chk_sig(rr, `RESP_SLVERR);
		$display("test reset done");
		wr(`OFS_ACC_LOW, 8'hFE);
		wr(`OFS_ACC_HIGH, 8'hFF);
		wr(`OFS_ACC_UPPER, 8'h0F);
		wr(`OFS_STEP_LOW, 8'h03);
		rd_reg(`OFS_STEP_LOW);
		chk_reg(32'h03);
		wr(`OFS_CONTROL, 8'h80);
		pulse(3'h0, 1);
		rd_reg(`OFS_ACC_LOW);
		chk_reg(32'h01);
		rd_reg(`OFS_ACC_UPPER);
		chk_reg(32'h00);
		rd_reg(`OFS_CONTROL);
		chk_reg(32'hA0);
		chk_sig(nco_out, 1'h1);
		rd_reg(`OFS_IRQ);
		chk_reg(32'h01);
		wr(`OFS_IRQ, 8'h0F);
		repeat (3) @(posedge aclk);
		chk_sig(irq_request, 1'h1);
		wr(`OFS_IRQ, 8'h0E);
		repeat (3) @(posedge aclk);
		chk_sig(irq_request, 1'h0);
		$display("test overflow done");
		wr(`OFS_STEP_HIGH, 8'h00);
		wr(`OFS_STEP_LOW, 8'h10);
		pulse(3'h0, 1);
		rd_reg(`OFS_ACC_LOW);
		chk_reg(32'h04);
		pulse(3'h0, 2);
		rd_reg(`OFS_ACC_LOW);
		chk_reg(32'h17);
		wr(`OFS_IRQ, 8'h02);
		wr(`OFS_CONTROL, 8'h90);
		repeat (3) @(posedge aclk);
		chk_sig(nco_out, 1'h0);
		rd_reg(`OFS_IRQ);
		chk_reg(32'h03);
		$display("test buffer and polarity done");
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(`OFS_CONTROL, 8'h00);
			wr(`OFS_ACC_LOW, 8'h00);
			wr(`OFS_STEP_LOW, 8'h01);
			wr(`OFS_CLOCK, i[7:0]);
			wr(`OFS_CONTROL, 8'h80);
			repeat (2) @(posedge aclk);
			chk_sig(fast_osc_keep_on, i == 1);
			pulse(i[2:0], 1);
			rd_reg(`OFS_ACC_LOW);
			chk_reg(i < 6);
		end
		$display("test sources done");
		// step 0x01000 overflows every 256 edges, above the widest pulse
		for (w = 0; w < 8; w = w + 1)
		begin
			wr(`OFS_CONTROL, 8'h00);
			wr(`OFS_ACC_LOW, 8'h00);
			wr(`OFS_ACC_HIGH, 8'hF0);
			wr(`OFS_ACC_UPPER, 8'h0F);
			wr(`OFS_STEP_LOW, 8'h00);
			wr(`OFS_STEP_HIGH, 8'h10);
			wr(`OFS_CLOCK, {w[2:0], 5'h00});
			wr(`OFS_CONTROL, 8'h81);
			pulse(3'h0, 1 << w);
			chk_sig(nco_out, 1'h1);
			pulse(3'h0, 1);
			chk_sig(nco_out, 1'h0);
		end
		$display("test pulse mode done");
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd_reg(`OFS_CONTROL);
		chk_reg(32'h0);
		rd_reg(`OFS_ACC_UPPER);
		chk_reg(32'h0);
		rd_reg(`OFS_STEP_HIGH);
		chk_reg(32'h0);
		chk_sig(nco_out, 1'h0);
		$display("test second reset done");
		final_report;
	end
endmodule // tb_phase_accumulator_oscillator
